/* rtl/pcc_pkg.sv */
// Constants shared by the comparator control register block.
package pcc_pkg;

    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL   = 8'h09;
    localparam logic [7:0] IDX_FPER   = 8'h0A;
    localparam logic [7:0] IDX_STATUS = 8'h0B;
    localparam logic [7:0] ADDR_CTRL   = {IDX_CTRL[5:0], 2'b00};
    localparam logic [7:0] ADDR_FPER   = {IDX_FPER[5:0], 2'b00};
    localparam logic [7:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'b00};

    // ------------------------------------------------------------
    // Field positions of the second control register
    // ------------------------------------------------------------
    localparam int BIT_SAMPLE = 7;
    localparam int BIT_WINDOW = 6;
    localparam int BIT_RSVD   = 5;
    localparam int BIT_POWER  = 4;
    localparam int BIT_INVERT = 3;
    localparam int BIT_SOURCE = 2;
    localparam int BIT_PIN_EN = 1;
    localparam int BIT_ENABLE = 0;

    // Status register field positions.
    localparam int STAT_FILTERED_COMPARE_OUT   = 0;
    localparam int STAT_ON     = 1;
    localparam int STAT_RESULT = 2;

    // ------------------------------------------------------------
    // Reset values and bus answers
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_FPER = 8'h00;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

/* rtl/pcc_filter.sv */
// Sampling output filter of the phase comparator.
`timescale 1ns/100ps
module pcc_filter
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       enable,
    input  wire logic       sample_mode,
    input  wire logic       sample_pulse,
    input  wire logic [7:0] filter_period,
    input  wire logic       raw_in,
    output logic            filt_out
);

    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic       next_filt_out;
    logic       strobe;

    // ------------------------------------------------------------
    // Sample strobe and output register
    // ------------------------------------------------------------
    always_comb
    begin
        next_cnt      = cnt;
        next_filt_out = filt_out;
        strobe        = 1'b0;
        if (sample_mode)
        begin
            strobe = sample_pulse;
        end
        else if (filter_period == 8'h00)
        begin
            strobe = 1'b1;
        end
        else if (cnt >= filter_period - 8'h01)
        begin
            strobe = 1'b1;
        end
        if (!enable || sample_mode || strobe)
        begin
            next_cnt = 8'h00;
        end
        else
        begin
            next_cnt = cnt + 8'h01;
        end
        if (!enable)
        begin
            next_filt_out = 1'b0;
        end
        else if (strobe)
        begin
            next_filt_out = raw_in;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt      <= 8'h00;
            filt_out <= 1'b0;
        end
        else
        begin
            cnt      <= next_cnt;
            filt_out <= next_filt_out;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_ext_sample_hold: assert property (
        (enable && sample_mode && !sample_pulse && $past(enable)) |=> $stable(filt_out))
        else $error("filter output moved without an external sample");

endmodule

/* rtl/pcc_ctrl.sv */
// AXI4-Lite control register bank of the phase comparator.
// Contract
// - A write that sets both mode bits keeps sampling mode and clears windowing mode.
// - The sampling mode bit selects sampling mode when one.
// - The windowing mode bit selects windowing mode when one.
// - Bit five is read-only, reads as zero and ignores writes.
// - The power mode bit picks low speed at zero and high speed at one.
// - The invert bit sets the polarity of the comparator result.
// - While pin enable is zero the invert bit drives the compare output pin and status bit.
// - The output source bit is held off and writing one has no effect.
// - The pin enable bit is held off so the output never reaches its pin.
// - The module enable bit turns the comparator on; at zero it is held off.
// - Equal mux selections on both comparator inputs disable the comparator.
// - While disabled the status output bit reads the invert bit.
// - In sampling mode the external sample signal sets the filter sample period.
`timescale 1ns/100ps
module pcc_ctrl
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic [2:0]  mux_pos_sel,
    input  wire logic [2:0]  mux_neg_sel,
    input  wire logic        raw_compare_out,
    input  wire logic        ext_sample,
    output logic             comparator_on,
    output logic             sample_mode,
    output logic             window_mode,
    output logic             high_speed_mode,
    output logic             output_invert,
    output logic             compare_pin_out,
    output logic             compare_result
);

    function automatic logic pcc_hit(input logic [7:0] addr, input logic [7:0] target);
        pcc_hit = (addr[7:2] == target[7:2]);
    endfunction

    function automatic logic pcc_mapped(input logic [7:0] addr);
        pcc_mapped = pcc_hit(addr, pcc_pkg::ADDR_CTRL) || pcc_hit(addr, pcc_pkg::ADDR_FPER)
                     || pcc_hit(addr, pcc_pkg::ADDR_STATUS);
    endfunction

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [7:0]  w_byte;
    logic        w_lane0;
    logic        next_aw_held;
    logic [7:0]  next_aw_addr;
    logic        next_w_held;
    logic [7:0]  next_w_byte;
    logic        next_w_lane0;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        wr_go;
    logic        wr_ctrl;
    logic        wr_fper;

    assign awready = !aw_held && !bvalid;
    assign wready  = !w_held && !bvalid;
    assign wr_go   = aw_held && w_held && !bvalid;
    assign wr_ctrl = wr_go && w_lane0 && pcc_hit(aw_addr, pcc_pkg::ADDR_CTRL);
    assign wr_fper = wr_go && w_lane0 && pcc_hit(aw_addr, pcc_pkg::ADDR_FPER);

    always_comb
    begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_byte  = w_byte;
        next_w_lane0 = w_lane0;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        if (awvalid && awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready)
        begin
            next_w_held  = 1'b1;
            next_w_byte  = wdata[7:0];
            next_w_lane0 = wstrb[0];
        end
        if (wr_go)
        begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = pcc_mapped(aw_addr) ? pcc_pkg::RESP_OKAY : pcc_pkg::RESP_SLVERR;
        end
        else if (bvalid && bready)
        begin
            next_bvalid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held  <= 1'b0;
            w_byte  <= 8'h00;
            w_lane0 <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= pcc_pkg::RESP_OKAY;
        end
        else
        begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held  <= next_w_held;
            w_byte  <= next_w_byte;
            w_lane0 <= next_w_lane0;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
        end
    end

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    logic       module_enable;
    logic [7:0] filter_period;
    logic       next_sample_mode;
    logic       next_window_mode;
    logic       next_high_speed;
    logic       next_invert;
    logic       next_enable;
    logic [7:0] next_fper;
    logic [7:0] ctrl_word;

    always_comb
    begin
        next_sample_mode = sample_mode;
        next_window_mode = window_mode;
        next_high_speed  = high_speed_mode;
        next_invert      = output_invert;
        next_enable      = module_enable;
        next_fper        = filter_period;
        if (wr_ctrl)
        begin
            next_sample_mode = w_byte[pcc_pkg::BIT_SAMPLE];
            // Sampling wins when both mode bits are written as one.
            next_window_mode = w_byte[pcc_pkg::BIT_WINDOW]
                               && !w_byte[pcc_pkg::BIT_SAMPLE];
            next_high_speed  = w_byte[pcc_pkg::BIT_POWER];
            next_invert      = w_byte[pcc_pkg::BIT_INVERT];
            next_enable      = w_byte[pcc_pkg::BIT_ENABLE];
        end
        if (wr_fper)
        begin
            next_fper = w_byte;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sample_mode     <= pcc_pkg::RST_CTRL[pcc_pkg::BIT_SAMPLE];
            window_mode     <= pcc_pkg::RST_CTRL[pcc_pkg::BIT_WINDOW];
            high_speed_mode <= pcc_pkg::RST_CTRL[pcc_pkg::BIT_POWER];
            output_invert   <= pcc_pkg::RST_CTRL[pcc_pkg::BIT_INVERT];
            module_enable   <= pcc_pkg::RST_CTRL[pcc_pkg::BIT_ENABLE];
            filter_period   <= pcc_pkg::RST_FPER;
        end
        else
        begin
            sample_mode     <= next_sample_mode;
            window_mode     <= next_window_mode;
            high_speed_mode <= next_high_speed;
            output_invert   <= next_invert;
            module_enable   <= next_enable;
            filter_period   <= next_fper;
        end
    end

    // Reserved, source select and pin enable bits always read zero.
    always_comb
    begin
        ctrl_word                     = 8'h00;
        ctrl_word[pcc_pkg::BIT_SAMPLE] = sample_mode;
        ctrl_word[pcc_pkg::BIT_WINDOW] = window_mode;
        ctrl_word[pcc_pkg::BIT_POWER]  = high_speed_mode;
        ctrl_word[pcc_pkg::BIT_INVERT] = output_invert;
        ctrl_word[pcc_pkg::BIT_ENABLE] = module_enable;
    end

    // ------------------------------------------------------------
    // Comparator path
    // ------------------------------------------------------------
    logic [2:0] sync_pipe;
    logic [1:0] raw_sync;
    logic [2:0] next_sync_pipe;
    logic [1:0] next_raw_sync;
    logic       sample_pulse;

    assign comparator_on   = module_enable && (mux_pos_sel != mux_neg_sel);
    assign sample_pulse    = sync_pipe[1] && !sync_pipe[2];
    // The pin path is fused off, so the pin carries the polarity bit.
    assign compare_pin_out = output_invert;

    always_comb
    begin
        next_sync_pipe = {sync_pipe[1:0], ext_sample};
        next_raw_sync  = {raw_sync[0], raw_compare_out};
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync_pipe <= 3'b000;
            raw_sync  <= 2'b00;
        end
        else
        begin
            sync_pipe <= next_sync_pipe;
            raw_sync  <= next_raw_sync;
        end
    end

    pcc_filter u_filter
    (
        .clk           (clk),
        .resetn        (resetn),
        .enable        (comparator_on),
        .sample_mode   (sample_mode),
        .sample_pulse  (sample_pulse),
        .filter_period (filter_period),
        .raw_in        (raw_sync[1] ^ output_invert),
        .filt_out      (compare_result)
    );

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic [31:0] status_word;

    assign arready = !rvalid;

    always_comb
    begin
        status_word                      = 32'h0000_0000;
        status_word[pcc_pkg::STAT_FILTERED_COMPARE_OUT]   = output_invert;
        status_word[pcc_pkg::STAT_ON]     = comparator_on;
        status_word[pcc_pkg::STAT_RESULT] = compare_result;
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (arvalid && arready)
        begin
            next_rvalid = 1'b1;
            next_rresp  = pcc_mapped(araddr) ? pcc_pkg::RESP_OKAY : pcc_pkg::RESP_SLVERR;
            next_rdata  = 32'h0000_0000;
            if (pcc_hit(araddr, pcc_pkg::ADDR_CTRL))
            begin
                next_rdata = {24'h00_0000, ctrl_word};
            end
            else if (pcc_hit(araddr, pcc_pkg::ADDR_FPER))
            begin
                next_rdata = {24'h00_0000, filter_period};
            end
            else if (pcc_hit(araddr, pcc_pkg::ADDR_STATUS))
            begin
                next_rdata = status_word;
            end
        end
        else if (rvalid && rready)
        begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= pcc_pkg::RESP_OKAY;
        end
        else
        begin
            rvalid <= next_rvalid;
            rdata  <= next_rdata;
            rresp  <= next_rresp;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence seq_ctrl_write;
        wr_ctrl;
    endsequence

    sequence seq_status_read;
        arvalid && arready && pcc_hit(araddr, pcc_pkg::ADDR_STATUS) ##1 rvalid;
    endsequence

    sequence seq_ctrl_read;
        arvalid && arready && pcc_hit(araddr, pcc_pkg::ADDR_CTRL) ##1 rvalid;
    endsequence

    chk_modes_exclusive: assert property (!(sample_mode && window_mode))
        else $error("sampling and windowing active together");

    chk_both_modes_written: assert property (
        wr_ctrl && (w_byte[7:6] == 2'b11) |=> sample_mode && !window_mode)
        else $error("double mode write did not resolve to sampling");

    chk_sample_bit: assert property (
        seq_ctrl_write |=> sample_mode == $past(w_byte[pcc_pkg::BIT_SAMPLE]))
        else $error("sampling mode does not follow write");

    chk_window_bit: assert property (
        seq_ctrl_write |=> window_mode == ($past(w_byte[6]) && !$past(w_byte[7])))
        else $error("windowing mode does not follow write");

    chk_power_bit: assert property (
        seq_ctrl_write |=> high_speed_mode == $past(w_byte[pcc_pkg::BIT_POWER]))
        else $error("power mode does not follow write");

    chk_fixed_bits_zero: assert property (
        seq_ctrl_read |-> rdata[5:1] == {1'b0, $past(high_speed_mode), $past(output_invert), 2'b00})
        else $error("reserved or disabled control bits read nonzero");

    chk_pin_polarity: assert property (compare_pin_out == output_invert)
        else $error("compare pin does not carry the polarity bit");

    chk_status_filtered_compare_out: assert property (
        seq_status_read |-> rdata[pcc_pkg::STAT_FILTERED_COMPARE_OUT] == $past(output_invert))
        else $error("status output bit differs from polarity bit");

    chk_same_input_off: assert property (
        (mux_pos_sel == mux_neg_sel) |-> !comparator_on ##1 !compare_result)
        else $error("comparator not disabled for equal inputs");

    chk_disabled_quiet: assert property (
        !module_enable [*2] |-> !comparator_on && !compare_result)
        else $error("comparator active while disabled");

    chk_write_latency: assert property (
        wr_ctrl && (w_byte[0] != module_enable) |=> $changed(module_enable) && bvalid)
        else $error("enable write not applied at next edge");

endmodule

/* test/pcc_comp_model.sv */
// Behavioural model of the analog comparator core and its external sample source.
`timescale 1ns/100ps
module pcc_comp_model
(
    input  wire logic clk,
    input  wire logic powered,
    input  wire logic level,
    input  wire logic sample_req,
    output logic      raw_compare_out,
    output logic      ext_sample
);
    // ------------------------------------------------------------
    // Core output and sample source
    // ------------------------------------------------------------
    logic noise = 1'b0;
    logic sample_q = 1'b0;

    assign ext_sample = sample_q;

    // An unpowered core gives no valid result, so its output wanders every cycle.
    always @(posedge clk)
        noise <= ~noise;

    assign raw_compare_out = powered ? level : noise;

    // The sample source changes just after a clock edge, like a real timer output.
    always @(posedge clk)
        sample_q <= sample_req;
endmodule

/* test/tb_top.sv */
// Self-checking bench for the comparator control register block.
`timescale 1ns/100ps
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin num_errors++; $display("FAIL %0t %s", $time, m); end end
module tb_top;
    // ------------------------------------------------------------
    // Signals, clock and partner
    // ------------------------------------------------------------
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  wstrb = 4'h0;
    logic        wvalid = 1'b0;
    logic        wready_w;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready = 1'b0;
    logic [7:0]  araddr = 8'h00;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready = 1'b0;
    logic [2:0]  mux_pos_sel = 3'h1;
    logic [2:0]  mux_neg_sel = 3'h2;
    logic        raw_compare_out;
    logic        ext_sample;
    logic        level = 1'b0;
    logic        sample_req = 1'b0;
    logic        comparator_on;
    logic        sample_mode;
    logic        window_mode;
    logic        high_speed_mode;
    logic        output_invert;
    logic        compare_pin_out;
    logic        compare_result;
    logic [31:0] rdd;
    logic [1:0]  rs;
    int          num_errors = 0;
    int          checks = 0;

    always #25 clk = ~clk;

    pcc_ctrl dut_u (.clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready_w),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .mux_pos_sel(mux_pos_sel), .mux_neg_sel(mux_neg_sel), .raw_compare_out(raw_compare_out),
        .ext_sample(ext_sample), .comparator_on(comparator_on), .sample_mode(sample_mode),
        .window_mode(window_mode), .high_speed_mode(high_speed_mode),
        .output_invert(output_invert), .compare_pin_out(compare_pin_out),
        .compare_result(compare_result));

    pcc_comp_model model_u (.clk(clk), .powered(comparator_on), .level(level),
        .sample_req(sample_req), .raw_compare_out(raw_compare_out), .ext_sample(ext_sample));

    // ------------------------------------------------------------
    // Bus tasks and report
    // ------------------------------------------------------------
    task automatic final_report;
        begin
            $display("errors %0d checks %0d", num_errors, checks);
            if (num_errors == 0 && checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    task automatic tmo;
        begin
            num_errors++;
            $display("FAIL %0t wait ran out", $time);
            final_report();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        int n;
        begin
            @(posedge clk);
            awaddr  <= a;
            wdata   <= d;
            wstrb   <= s;
            awvalid <= 1'b1;
            wvalid  <= 1'b1;
            bready  <= 1'b1;
            for (n = 0; n < 50; n++)
            begin
                @(posedge clk);
                if (awvalid && awready)
                    awvalid <= 1'b0;
                if (wvalid && wready_w)
                    wvalid <= 1'b0;
                if (bvalid && bready)
                    break;
            end
            r = bresp;
            bready <= 1'b0;
            if (n == 50)
                tmo();
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        begin
            @(posedge clk);
            araddr  <= a;
            arvalid <= 1'b1;
            rready  <= 1'b1;
            for (n = 0; n < 50; n++)
            begin
                @(posedge clk);
                if (arvalid && arready)
                    arvalid <= 1'b0;
                if (rvalid && rready)
                    break;
            end
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            if (n == 50)
                tmo();
        end
    endtask

    task automatic wctrl(input logic [7:0] v);
        begin
            wr(pcc_pkg::ADDR_CTRL, {24'h00_0000, v}, 4'h1, rs);
            `CHK(rs, pcc_pkg::RESP_OKAY, "ctrl write resp")
        end
    endtask

    task automatic wait_result(input logic e);
        int n;
        begin
            for (n = 0; n < 20 && compare_result !== e; n++)
                @(posedge clk);
            if (n == 20)
                tmo();
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_bits;
        int i;
        logic [7:0] v;
        begin
            for (i = 0; i < 8; i++)
            begin
                v = 8'h01 << i;
                wctrl(v);
                `CHK(sample_mode, v[7], "sample mode")
                `CHK(window_mode, v[6], "window mode")
                `CHK(high_speed_mode, v[4], "speed mode")
                `CHK(output_invert, v[3], "invert")
                `CHK(compare_pin_out, v[3], "pin level")
                `CHK(comparator_on, v[0], "enable")
                rd(pcc_pkg::ADDR_CTRL, rdd, rs);
                `CHK(rs, pcc_pkg::RESP_OKAY, "ctrl read resp")
                `CHK(rdd, {24'h00_0000, v & 8'hD9}, "ctrl readback")
            end
            $display("test bits done");
        end
    endtask

    task automatic t_both;
        begin
            // Deliberately breaks the software rule to see the documented outcome.
            wctrl(8'hC0);
            `CHK(sample_mode, 1'b1, "both sample")
            `CHK(window_mode, 1'b0, "both window")
            rd(pcc_pkg::ADDR_CTRL, rdd, rs);
            `CHK(rdd, 32'h0000_0080, "both readback")
            wr(pcc_pkg::ADDR_CTRL, 32'h0000_00FF, 4'h0, rs);
            rd(pcc_pkg::ADDR_CTRL, rdd, rs);
            `CHK(rdd, 32'h0000_0080, "strobe off ignored")
            $display("test both modes done");
        end
    endtask

    task automatic t_auto_off;
        begin
            level <= 1'b1;
            wctrl(8'h01);
            wait_result(1'b1);
            `CHK(compare_result, 1'b1, "result before off")
            mux_neg_sel <= 3'h1;
            @(posedge clk);
            @(posedge clk);
            `CHK(comparator_on, 1'b0, "equal inputs off")
            rd(pcc_pkg::ADDR_STATUS, rdd, rs);
            `CHK(rdd[1], 1'b0, "status off")
            `CHK(compare_result, 1'b0, "result while off")
            mux_neg_sel <= 3'h2;
            @(posedge clk);
            @(posedge clk);
            `CHK(comparator_on, 1'b1, "distinct inputs on")
            wait_result(1'b1);
            `CHK(compare_result, 1'b1, "result after on")
            $display("test auto off done");
        end
    endtask

    task automatic t_off_invert;
        begin
            wctrl(8'h08);
            rd(pcc_pkg::ADDR_STATUS, rdd, rs);
            `CHK(rdd, 32'h0000_0001, "status shows invert")
            `CHK(compare_pin_out, 1'b1, "pin shows invert")
            wctrl(8'h00);
            rd(pcc_pkg::ADDR_STATUS, rdd, rs);
            `CHK(rdd, 32'h0000_0000, "status clear")
            $display("test off invert done");
        end
    endtask

    task automatic t_filter;
        int n;
        begin
            level <= 1'b1;
            wctrl(8'h01);
            wait_result(1'b1);
            `CHK(compare_result, 1'b1, "plain result")
            wr(pcc_pkg::ADDR_FPER, 32'h0000_0004, 4'h1, rs);
            rd(pcc_pkg::ADDR_FPER, rdd, rs);
            `CHK(rdd, 32'h0000_0004, "period readback")
            wctrl(8'h09);
            wait_result(1'b0);
            `CHK(compare_result, 1'b0, "inverted result")
            wctrl(8'h81);
            for (n = 0; n < 10; n++)
            begin
                @(posedge clk);
                `CHK(compare_result, 1'b0, "held until sample")
            end
            sample_req <= 1'b1;
            repeat (3) @(posedge clk);
            sample_req <= 1'b0;
            wait_result(1'b1);
            `CHK(compare_result, 1'b1, "sampled result")
            level <= 1'b0;
            wctrl(8'h00);
            $display("test filter done");
        end
    endtask

    task automatic t_map;
        begin
            rd(pcc_pkg::ADDR_CTRL, rdd, rs);
            `CHK(rdd, 32'h0000_0000, "ctrl after use")
            wr(8'h00, 32'h0000_00FF, 4'h1, rs);
            `CHK(rs, pcc_pkg::RESP_SLVERR, "unmapped write")
            rd(8'h00, rdd, rs);
            `CHK(rs, pcc_pkg::RESP_SLVERR, "unmapped read resp")
            `CHK(rdd, 32'h0000_0000, "unmapped read data")
            wr(pcc_pkg::ADDR_STATUS, 32'h0000_00FF, 4'h1, rs);
            `CHK(rs, pcc_pkg::RESP_OKAY, "status write resp")
            rd(pcc_pkg::ADDR_STATUS, rdd, rs);
            `CHK(rdd, 32'h0000_0000, "status read only")
            $display("test map done");
        end
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rd(pcc_pkg::ADDR_CTRL, rdd, rs);
        `CHK(rdd, {24'h00_0000, pcc_pkg::RST_CTRL}, "ctrl reset value")
        t_bits();
        t_both();
        t_auto_off();
        t_off_invert();
        t_filter();
        t_map();
        final_report();
    end
endmodule
